/* rtl/drc_refresh.sv */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module drc_refresh
	import drc_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Falling-edge marker of the processor output clock, synchronous to ref_clk_i.
	input wire logic cpu_out_clock_fall_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Bus interface unit side.
	input wire logic refresh_done_i,
	output drc_req_t refresh_o,
	output logic byte_high_enable_o
);
	// Software-visible storage.
	logic [DRC_BASE_W-1:0] base_addr;
	logic [DRC_BASE_W-1:0] next_base_addr;
	logic [DRC_CNT_W-1:0] interval;
	logic [DRC_CNT_W-1:0] next_interval;
	logic enable;
	logic next_enable;
	// Engine state.
	drc_state_t state;
	drc_state_t next_state;
	logic [DRC_CNT_W-1:0] count;
	logic [DRC_CNT_W-1:0] next_count;
	logic [DRC_ROW_W-1:0] row;
	logic [DRC_ROW_W-1:0] next_row;
	logic req;
	logic next_req;
	logic [31:0] next_prdata;
	// Access strobes and decodes; the slave answers with no wait states.
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic [DRC_ROW_W-1:0] lfsr_step;

	// The access strobes are plain decodes of the bus. A write lands in the
	// access phase, a read is captured in the setup phase, so pready can stay
	// high without a wait state and the read data still leave a flip-flop.
	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign rd_acc = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	// Unmapped addresses are flagged as errors, which APB allows.
	assign mapped = (paddr_i == DRC_BASE_OFS) || (paddr_i == DRC_INTV_OFS) ||
		(paddr_i == DRC_CTRL_OFS) || (paddr_i == DRC_ROW_OFS);
	assign pslverr_o = psel_i & penable_i & ~mapped;

	// Galois step of the row counter; the zero state is mapped into the loop
	// so that all 4096 values are visited once per period.
	always_comb begin
		lfsr_step = {row[DRC_ROW_W-2:0], 1'b0} ^ (row[DRC_ROW_W-1] ? DRC_LFSR_TAPS : '0);
		// Zero would lock a plain shift counter, so it is spliced in between
		// the state that normally steps to one and one itself.
		if (row == DRC_ROW_RST) begin
			lfsr_step = DRC_ROW_ONE;
		end else if (row == DRC_LFSR_LAST) begin
			lfsr_step = DRC_ROW_RST;
		end
	end

	// Register writes; reads of the counter bits never store anything.
	always_comb begin
		next_base_addr = base_addr;
		next_interval = interval;
		next_enable = enable;
		if (wr_acc) begin
			if (paddr_i == DRC_BASE_OFS) begin
				next_base_addr = pwdata_i[DRC_BASE_LSB +: DRC_BASE_W];
			end else if (paddr_i == DRC_INTV_OFS) begin
				next_interval = pwdata_i[DRC_CNT_W-1:0];
			end else if (paddr_i == DRC_CTRL_OFS) begin
				// Only the enable bit takes; the count field is ignored.
				next_enable = pwdata_i[DRC_EN_BIT];
			end
		end
	end

	// Counter engine, advanced only on processor-clock falling edges.
	// The counter never waits for the bus unit: requests keep their spacing
	// however busy the bus is, at the price of losing one that is not served.
	always_comb begin
		next_state = state;
		next_count = count;
		next_req = req;
		next_row = row;
		// Completion clears the request and steps the row; base is untouched.
		if (refresh_done_i && req) begin
			next_req = 1'b0;
			next_row = lfsr_step;
		end
		case (state)
			DRC_OFF: begin
				next_count = DRC_CNT_RST;
				if (enable && cpu_out_clock_fall_i) begin
					// The first marker after the enable write already loads,
					// so no falling edge is lost to the idle state.
					next_count = interval;
					next_state = DRC_RUN;
				end else if (enable) begin
					// Wait in the load state for the next marker.
					next_state = DRC_LOAD;
				end
			end
			DRC_LOAD: begin
				if (!enable) begin
					next_state = DRC_OFF;
					next_count = DRC_CNT_RST;
				end else if (cpu_out_clock_fall_i) begin
					next_count = interval;
					next_state = DRC_RUN;
				end
			end
			default: begin
				if (!enable) begin
					next_state = DRC_OFF;
					next_count = DRC_CNT_RST;
				end else if (cpu_out_clock_fall_i) begin
					if (count <= DRC_CNT_ONE) begin
						// A fresh request overwrites an unserviced one.
						next_count = interval;
						next_req = 1'b1;
					end else begin
						next_count = count - DRC_CNT_ONE;
					end
				end
			end
		endcase
	end

	// Read mux, registered in the setup phase so data leave a flip-flop.
	always_comb begin
		next_prdata = '0;
		if (paddr_i == DRC_BASE_OFS) begin
			next_prdata[DRC_BASE_LSB +: DRC_BASE_W] = base_addr;
		end else if (paddr_i == DRC_INTV_OFS) begin
			next_prdata[DRC_CNT_W-1:0] = interval;
		end else if (paddr_i == DRC_CTRL_OFS) begin
			next_prdata[DRC_EN_BIT] = enable;
			next_prdata[DRC_CNT_W-1:0] = count;
		end else if (paddr_i == DRC_ROW_OFS) begin
			next_prdata[DRC_ROW_W:1] = row;
			next_prdata[0] = DRC_A0_VAL;
		end
	end

	// All state registers; clk_en_i low freezes everything.
	// A completion pulse that arrives while frozen is not seen, so the request
	// simply stays pending until the bus unit serves it again.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			base_addr <= DRC_BASE_RST;
			interval <= DRC_CNT_RST;
			enable <= 1'b0;
			state <= DRC_OFF;
			count <= DRC_CNT_RST;
			row <= DRC_ROW_RST;
			req <= 1'b0;
			prdata_o <= '0;
		end else if (clk_en_i) begin
			base_addr <= next_base_addr;
			interval <= next_interval;
			enable <= next_enable;
			state <= next_state;
			count <= next_count;
			row <= next_row;
			req <= next_req;
			if (rd_acc) begin
				prdata_o <= next_prdata;
			end
		end
	end

	// Refresh address: base on top, row in the middle, A0 forced high.
	assign refresh_o.req = req;
	assign refresh_o.addr = {base_addr, row, DRC_A0_VAL};
	// The 16-bit variant marks refresh cycles with byte-high high.
	assign byte_high_enable_o = 1'b1;

	// Assertions.
	// A falling-edge marker seen while the engine runs and may act on it.
	sequence fall_while_run_s;
		clk_en_i && enable && state == DRC_RUN && cpu_out_clock_fall_i;
	endsequence
	// The same marker landing on a count of one or less: a new request.
	sequence new_request_s;
		clk_en_i && enable && state == DRC_RUN && cpu_out_clock_fall_i &&
			count <= DRC_CNT_ONE;
	endsequence
	// A completion pulse from the bus unit while a request is pending.
	sequence service_s;
		clk_en_i && refresh_done_i && req;
	endsequence
	// A completion that does not collide with a fresh request in that cycle.
	sequence lone_service_s;
		clk_en_i && refresh_done_i && req &&
			!(enable && state == DRC_RUN && cpu_out_clock_fall_i &&
			count <= DRC_CNT_ONE);
	endsequence

	reload_at_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		fall_while_run_s and count <= DRC_CNT_ONE |=> req && count == $past(interval))
		else $error("Reload at one failed.");
	decrement_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		fall_while_run_s and count > DRC_CNT_ONE |=> count == $past(count) - DRC_CNT_ONE)
		else $error("Counter did not decrement.");
	disable_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && !enable |=> count == DRC_CNT_RST)
		else $error("Counter not cleared while disabled.");
	row_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(clk_en_i && refresh_done_i && req) |=> row == $past(row))
		else $error("Row moved without completion.");
	row_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		service_s |=> row != $past(row))
		else $error("Row did not step on completion.");
	base_fixed_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(clk_en_i && wr_acc && paddr_i == DRC_BASE_OFS) |=> $stable(base_addr))
		else $error("Base changed without a write.");
	addr_bit0_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		refresh_o.addr[0] == DRC_A0_VAL && refresh_o.addr[DRC_ROW_W:1] == row)
		else $error("Refresh address malformed.");
	load_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state == DRC_LOAD && enable && cpu_out_clock_fall_i
		|=> state == DRC_RUN && count == $past(interval))
		else $error("Enable did not load interval.");
	// A pending request must survive until the bus unit reports completion;
	// losing it would skip a row and eat into that row's retention margin.
	req_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && req && !refresh_done_i |=> req)
		else $error("Request dropped before service.");
	// Completion alone clears the request.
	done_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		lone_service_s |=> !req)
		else $error("Request not cleared on completion.");
	// When completion and a new request meet, the new request wins.
	collide_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		service_s and new_request_s |=> req)
		else $error("Colliding request was lost.");
	// Enabling from idle loads the interval on the very first marker.
	off_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state == DRC_OFF && enable && cpu_out_clock_fall_i
		|=> state == DRC_RUN && count == $past(interval))
		else $error("First marker after enable did not load.");
	// With the clock enable low nothing moves, whatever the inputs do.
	freeze_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!clk_en_i |=> $stable(count) && $stable(row) && $stable(req) && $stable(state))
		else $error("State moved while frozen.");
	// The refresh address carries the base field on top, unchanged.
	base_in_addr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		refresh_o.addr[DRC_ROW_W+1 +: DRC_BASE_W] == base_addr)
		else $error("Base field missing from refresh address.");
	// Read data stand between read setups, so a slow master still sees them.
	prdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(clk_en_i && rd_acc) |=> $stable(prdata_o))
		else $error("Read data changed outside a read.");
	// A control write that keeps the unit running leaves the count alone
	// when no marker falls in that cycle; software cannot preset it.
	ctrl_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && wr_acc && paddr_i == DRC_CTRL_OFS && pwdata_i[DRC_EN_BIT] &&
		enable && state == DRC_RUN && !cpu_out_clock_fall_i |=> $stable(count))
		else $error("Control write changed the count.");
	// Interval writes only change the reload value, never the running count.
	intv_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && wr_acc && paddr_i == DRC_INTV_OFS && enable &&
		state == DRC_RUN && !cpu_out_clock_fall_i |=> $stable(count))
		else $error("Interval write changed the count.");
	// The byte-high marker must stand high on every cycle.
	bhe_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		byte_high_enable_o == 1'b1)
		else $error("Byte-high marker not high.");
endmodule

/* rtl/drc_pkg.sv */
package drc_pkg;
	// Byte addresses of the four registers on the APB slave.
	localparam logic [7:0] DRC_BASE_OFS = 8'h00;
	localparam logic [7:0] DRC_INTV_OFS = 8'h04;
	localparam logic [7:0] DRC_CTRL_OFS = 8'h08;
	localparam logic [7:0] DRC_ROW_OFS = 8'h0C;
	// Field widths and positions.
	localparam int DRC_CNT_W = 9;
	localparam int DRC_ROW_W = 12;
	localparam int DRC_BASE_W = 7;
	localparam int DRC_BASE_LSB = 6;
	localparam int DRC_EN_BIT = 15;
	// Reset values, and the constant one for the count and the row.
	localparam logic [DRC_CNT_W-1:0] DRC_CNT_RST = 9'h000;
	localparam logic [DRC_CNT_W-1:0] DRC_CNT_ONE = 9'h001;
	localparam logic [DRC_ROW_W-1:0] DRC_ROW_RST = 12'h000;
	localparam logic [DRC_ROW_W-1:0] DRC_ROW_ONE = 12'h001;
	localparam logic [DRC_BASE_W-1:0] DRC_BASE_RST = 7'h00;
	// Feedback taps of the 12-bit Galois counter, polynomial x^12+x^6+x^4+x+1.
	localparam logic [DRC_ROW_W-1:0] DRC_LFSR_TAPS = 12'h053;
	// The state whose plain successor is one; the zero state is spliced in after it.
	localparam logic [DRC_ROW_W-1:0] DRC_LFSR_LAST = 12'h829;
	// Refresh cycle markers: A0 is always one; the byte-high pin is high.
	localparam logic DRC_A0_VAL = 1'b1;
	// Request group carried to the bus interface unit.
	typedef struct packed {
		logic req;
		logic [19:0] addr;
	} drc_req_t;
	// Refresh enable state machine.
	typedef enum logic [1:0] {
		DRC_OFF = 2'b00,
		DRC_LOAD = 2'b01,
		DRC_RUN = 2'b10
	} drc_state_t;
endpackage

/* test/drc_biu_model.sv */
`timescale 1ns/1ps
// Bus unit stand-in: it answers a pending refresh request with a one-cycle done pulse.
module drc_biu_model
	import drc_pkg::*;
#(
	parameter int DLY = 6
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Request in, completion out.
	input wire drc_req_t refresh_i,
	output logic refresh_done_o
);
	// The dummy read takes DLY cycles; done is never sent without a request.
	initial begin
		refresh_done_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			if (!rst_i && refresh_i.req === 1'b1) begin
				repeat (DLY) @(posedge ref_clk_i);
				refresh_done_o <= 1'b1;
				@(posedge ref_clk_i);
				refresh_done_o <= 1'b0;
				@(posedge ref_clk_i);
			end
		end
	end
endmodule

/* test/drc_refresh_bench.sv */
`timescale 1ns/1ps
module drc_refresh_bench;
	import drc_pkg::*;
	logic ref_clk_i = 0, rst_i = 1, fall = 0, psel = 0, penable = 0, pwrite = 0, cen = 1;
	logic done, err, pready, pslverr, byte_high_enable;
	logic [7:0] paddr = 8'h00;
	logic [8:0] iv;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [1:0] div = 2'h0;
	int n_fall = 0, f_at, f0, cyc = 0, n_errors = 0, compares = 0;
	drc_req_t rf;
	always #4 ref_clk_i = ~ref_clk_i;
	// Falling-edge marker every fourth cycle; n_fall counts markers the block has seen.
	always @(posedge ref_clk_i) begin
		div <= div + 2'h1;
		fall <= (div == 2'h3);
		n_fall <= n_fall + int'(fall);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			finish_test();
		end
	end
	drc_refresh u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(cen),
		.cpu_out_clock_fall_i(fall), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .refresh_done_i(done), .refresh_o(rf), .byte_high_enable_o(byte_high_enable));
	drc_biu_model u_biu (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .refresh_i(rf),
		.refresh_done_o(done));
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the marker count is taken at the edge where the write lands.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		// Count the marker at this edge too: it cannot act on the new write.
		f_at = n_fall + int'(fall);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic wait_req(input logic lvl);
		do @(posedge ref_clk_i); while (rf.req !== lvl);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			cmp(q, (i == 3) ? 32'h1 : 32'h0);
		end
		apb(1'b0, 8'h10, 32'h0);
		cmp({31'h0, err}, 32'h1);
		apb(1'b1, DRC_BASE_OFS, 32'h1FC0);
		apb(1'b1, DRC_ROW_OFS, 32'hFFFF);
		apb(1'b0, DRC_BASE_OFS, 32'h0);
		cmp(q, 32'h1FC0);
		apb(1'b0, DRC_ROW_OFS, 32'h0);
		cmp(q, 32'h1);
		$display("register test finished");
		// The small interval and the 9-bit maximum, each from a fresh enable.
		for (int k = 0; k < 2; k++) begin
			iv = k ? 9'h1FF : 9'h003;
			apb(1'b1, DRC_CTRL_OFS, 32'h0);
			apb(1'b0, DRC_CTRL_OFS, 32'h0);
			cmp(q, 32'h0);
			wait_req(1'b0);
			apb(1'b1, DRC_INTV_OFS, {23'h0, iv});
			apb(1'b1, DRC_CTRL_OFS, 32'h81FF);
			f0 = f_at;
			wait_req(1'b1);
			cmp(n_fall - f0, iv + 1);
			cmp(32'(rf.addr[19:13]), 32'h7F);
			cmp({30'h0, rf.addr[0], byte_high_enable}, 32'h3);
			if (k == 0) cmp(32'(rf.addr[12:1]), 32'h0);
			f0 = n_fall;
			wait_req(1'b0);
			wait_req(1'b1);
			cmp(n_fall - f0, 32'(iv));
			if (k == 0) begin
				cmp(32'(rf.addr[12:1]), 32'h1);
				apb(1'b0, DRC_ROW_OFS, 32'h0);
				cmp(q, 32'h3);
			end
			apb(1'b0, DRC_CTRL_OFS, 32'h0);
			cmp(32'(q[15]), 32'h1);
			cmp({31'h0, q[8:0] <= iv}, 32'h1);
			$display("refresh test finished, interval %0d", iv);
		end
		// Freeze: with the clock enable low the request side must not move.
		cen <= 1'b0;
		@(posedge ref_clk_i);
		q = 32'(rf);
		repeat (40) @(posedge ref_clk_i);
		cmp(32'(rf), q);
		cen <= 1'b1;
		$display("freeze test finished");
		finish_test();
	end
endmodule
